// *** core/cilsu_lsu.sv ***
// Load/store unit for the compact instruction set
`default_nettype none

module cilsu_lsu (
	input wire logic clk_i,
	input wire logic reset_i,
	// Request from decode
	input wire logic req_valid_i,
	input wire cilsu_pkg::cilsu_op_t req_op_i,
	input wire cilsu_pkg::cilsu_base_t req_base_i,
	input wire logic req_src_ra_i,
	input wire logic [7:0] req_imm_i,
	input wire logic req_extended_i,
	input wire logic [15:0] req_ext_imm_i,
	input wire logic mode64_i,
	input wire logic kernel_i,
	input wire logic [63:0] base_register_i,
	input wire logic [63:0] stack_pointer_register_i,
	input wire logic [63:0] exception_return_pc_i,
	input wire logic [63:0] data_register_field_i,
	input wire logic [63:0] return_address_register_i,
	output logic req_ready_o,
	// Data memory path
	output logic mem_valid_o,
	output logic mem_write_o,
	output logic [63:0] mem_addr_o,
	output logic [7:0] mem_byte_en_o,
	output logic [63:0] mem_wdata_o,
	input wire logic mem_rvalid_i,
	input wire logic [63:0] mem_rdata_i,
	// Write-back and exceptions
	output logic wb_valid_o,
	output logic [63:0] wb_data_o,
	output logic addr_error_o,
	output logic reserved_instr_o,
	output logic [63:0] bad_vaddr_o
);

	// ==========================================================
	// Address generator
	cilsu_agen_if ag ();

	cilsu_agen u_agen (
		.port(ag.agen)
	);

	// ==========================================================
	// Decode of the requested operation
	logic [1:0] scale;
	logic [2:0] align;
	logic [7:0] lanes;
	logic is_load;
	logic is_signed;
	logic only64;
	logic reserved;
	logic accept;
	logic [63:0] src_data;

	always_comb begin
		scale = cilsu_pkg::SCALE_BYTE;
		is_load = 1'b0;
		is_signed = 1'b0;
		only64 = 1'b0;
		case (req_op_i)
			cilsu_pkg::load_byte_signed: begin
				is_load = 1'b1;
				is_signed = 1'b1;
			end
			cilsu_pkg::load_byte_unsigned: begin
				is_load = 1'b1;
			end
			cilsu_pkg::load_halfword_signed: begin
				scale = cilsu_pkg::SCALE_HALF;
				is_load = 1'b1;
				is_signed = 1'b1;
			end
			cilsu_pkg::load_halfword_unsigned: begin
				scale = cilsu_pkg::SCALE_HALF;
				is_load = 1'b1;
			end
			cilsu_pkg::load_word: begin
				scale = cilsu_pkg::SCALE_WORD;
				is_load = 1'b1;
				is_signed = 1'b1;
			end
			cilsu_pkg::load_word_unsigned: begin
				scale = cilsu_pkg::SCALE_WORD;
				is_load = 1'b1;
				only64 = 1'b1; // RULE_10
			end
			cilsu_pkg::load_doubleword: begin
				scale = cilsu_pkg::SCALE_DWORD;
				is_load = 1'b1;
				only64 = 1'b1; // RULE_10
			end
			cilsu_pkg::store_byte: begin
				scale = cilsu_pkg::SCALE_BYTE;
			end
			cilsu_pkg::store_halfword: begin
				scale = cilsu_pkg::SCALE_HALF;
			end
			cilsu_pkg::store_word: begin
				scale = cilsu_pkg::SCALE_WORD;
			end
			cilsu_pkg::store_doubleword: begin
				scale = cilsu_pkg::SCALE_DWORD;
				only64 = 1'b1; // RULE_10
			end
			default: begin
				scale = cilsu_pkg::SCALE_BYTE;
			end
		endcase
		case (scale)
			cilsu_pkg::SCALE_HALF: begin
				align = cilsu_pkg::ALIGN_HALF;
				lanes = cilsu_pkg::LANES_HALF;
			end
			cilsu_pkg::SCALE_WORD: begin
				align = cilsu_pkg::ALIGN_WORD;
				lanes = cilsu_pkg::LANES_WORD;
			end
			cilsu_pkg::SCALE_DWORD: begin
				align = cilsu_pkg::ALIGN_DWORD;
				lanes = cilsu_pkg::LANES_DWORD;
			end
			default: begin
				align = cilsu_pkg::ALIGN_BYTE;
				lanes = cilsu_pkg::LANES_BYTE;
			end
		endcase
		reserved = only64 && !mode64_i && !kernel_i; // RULE_10
	end

	// Address generator inputs: base choice and offset width
	always_comb begin
		case (req_base_i)
			cilsu_pkg::base_stack: ag.base = stack_pointer_register_i; // RULE_08 RULE_11
			cilsu_pkg::base_pc: ag.base = exception_return_pc_i; // RULE_19
			default: ag.base = base_register_i;
		endcase
		ag.pc_rel = (req_base_i == cilsu_pkg::base_pc);
		ag.wide = ((scale == cilsu_pkg::SCALE_WORD) && (req_base_i != cilsu_pkg::base_general))
			|| ((req_op_i == cilsu_pkg::store_doubleword) && req_src_ra_i); // RULE_07 RULE_14 RULE_17
		ag.short_imm = req_imm_i;
		ag.extended = req_extended_i;
		ag.ext_imm = req_ext_imm_i;
		ag.scale = scale;
		ag.align = align;
		src_data = req_src_ra_i ? return_address_register_i : data_register_field_i; // RULE_14 RULE_17
	end

	// ==========================================================
	// Control and memory request state
	cilsu_pkg::cilsu_state_t state_reg, state_next;
	logic ready_reg, ready_next;
	logic mem_valid_reg, mem_valid_next;
	logic mem_write_reg, mem_write_next;
	logic [63:0] mem_addr_reg, mem_addr_next;
	logic [7:0] mem_be_reg, mem_be_next;
	logic [63:0] mem_wdata_reg, mem_wdata_next;
	logic addr_err_reg, addr_err_next;
	logic resv_reg, resv_next;
	logic [63:0] bad_reg, bad_next;
	logic [1:0] scale_reg, scale_next;
	logic [2:0] align_reg, align_next;
	logic signed_reg, signed_next;
	logic mode64_reg, mode64_next;
	logic wb_valid_reg, wb_valid_next;
	logic [63:0] wb_data_reg, wb_data_next;
	logic [63:0] rd_shift;

	assign accept = ready_reg && req_valid_i;

	// Next state: exceptions first, then issue, then load return
	always_comb begin
		state_next = state_reg;
		ready_next = ready_reg;
		mem_valid_next = 1'b0;
		mem_write_next = mem_write_reg;
		mem_addr_next = mem_addr_reg;
		mem_be_next = mem_be_reg;
		mem_wdata_next = mem_wdata_reg;
		addr_err_next = 1'b0;
		resv_next = 1'b0;
		bad_next = bad_reg;
		scale_next = scale_reg;
		align_next = align_reg;
		signed_next = signed_reg;
		mode64_next = mode64_reg;
		wb_valid_next = 1'b0;
		wb_data_next = wb_data_reg;
		rd_shift = mem_rdata_i >> {mem_addr_reg[2:0], 3'h0};
		case (state_reg)
			cilsu_pkg::st_idle: begin
				if (accept) begin
					scale_next = scale;
					align_next = align;
					signed_next = is_signed;
					mode64_next = mode64_i;
					if (reserved) begin
						resv_next = 1'b1; // RULE_10 RULE_21
					end else if (ag.misaligned) begin
						addr_err_next = 1'b1; // RULE_04 RULE_06 RULE_12 RULE_21 RULE_22
						bad_next = ag.addr;
					end else begin
						mem_valid_next = 1'b1;
						mem_write_next = !is_load;
						mem_addr_next = ag.addr;
						mem_be_next = 8'(lanes << ag.addr[2:0]); // RULE_15 RULE_16 RULE_18
						mem_wdata_next = src_data << {ag.addr[2:0], 3'h0}; // RULE_15 RULE_16 RULE_18
						if (is_load) begin
							state_next = cilsu_pkg::st_wait_load;
							ready_next = 1'b0;
						end
					end
				end
			end
			cilsu_pkg::st_wait_load: begin
				if (mem_rvalid_i) begin
					wb_valid_next = 1'b1;
					ready_next = 1'b1;
					state_next = cilsu_pkg::st_idle;
					case (scale_reg)
						cilsu_pkg::SCALE_BYTE: wb_data_next = signed_reg ? {{56{rd_shift[7]}}, rd_shift[7:0]}
							: {{56{1'b0}}, rd_shift[7:0]}; // RULE_02
						cilsu_pkg::SCALE_HALF: wb_data_next = signed_reg ? {{48{rd_shift[15]}}, rd_shift[15:0]}
							: {{48{1'b0}}, rd_shift[15:0]}; // RULE_03
						cilsu_pkg::SCALE_WORD: wb_data_next = (signed_reg && mode64_reg)
							? {{32{rd_shift[31]}}, rd_shift[31:0]} : {{32{1'b0}}, rd_shift[31:0]}; // RULE_05 RULE_09
						default: wb_data_next = rd_shift;
					endcase
				end
			end
			default: begin
				state_next = cilsu_pkg::st_idle;
				ready_next = 1'b1;
			end
		endcase
	end

	// Register all state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= cilsu_pkg::st_idle;
			ready_reg <= 1'b1;
			mem_valid_reg <= 1'b0;
			mem_write_reg <= 1'b0;
			mem_addr_reg <= 64'h0000_0000_0000_0000;
			mem_be_reg <= 8'h00;
			mem_wdata_reg <= 64'h0000_0000_0000_0000;
			addr_err_reg <= 1'b0;
			resv_reg <= 1'b0;
			bad_reg <= 64'h0000_0000_0000_0000;
			scale_reg <= cilsu_pkg::SCALE_BYTE;
			align_reg <= cilsu_pkg::ALIGN_BYTE;
			signed_reg <= 1'b0;
			mode64_reg <= 1'b0;
			wb_valid_reg <= 1'b0;
			wb_data_reg <= 64'h0000_0000_0000_0000;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			mem_valid_reg <= mem_valid_next;
			mem_write_reg <= mem_write_next;
			mem_addr_reg <= mem_addr_next;
			mem_be_reg <= mem_be_next;
			mem_wdata_reg <= mem_wdata_next;
			addr_err_reg <= addr_err_next;
			resv_reg <= resv_next;
			bad_reg <= bad_next;
			scale_reg <= scale_next;
			align_reg <= align_next;
			signed_reg <= signed_next;
			mode64_reg <= mode64_next;
			wb_valid_reg <= wb_valid_next;
			wb_data_reg <= wb_data_next;
		end
	end

	// Outputs straight from flops
	assign req_ready_o = ready_reg;
	assign mem_valid_o = mem_valid_reg;
	assign mem_write_o = mem_write_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_byte_en_o = mem_be_reg;
	assign mem_wdata_o = mem_wdata_reg;
	assign wb_valid_o = wb_valid_reg;
	assign wb_data_o = wb_data_reg;
	assign addr_error_o = addr_err_reg;
	assign reserved_instr_o = resv_reg;
	assign bad_vaddr_o = bad_reg;

	// ==========================================================
	// Assertions
	logic [63:0] imm5_zx;
	assign imm5_zx = {{59{1'b0}}, req_imm_i[4:0]};

	a_reserved_blocks: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_10
		accept && reserved |=> reserved_instr_o && !mem_valid_o && !addr_error_o)
		else $error("reserved op not trapped");
	a_issue_aligned: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_12
		mem_valid_o |-> ((mem_addr_o[2:0] & align_reg) == 3'h0))
		else $error("misaligned access issued");
	a_error_misaligned: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_04
		addr_error_o |-> ((bad_vaddr_o[2:0] & align_reg) != 3'h0) && !mem_valid_o)
		else $error("address error on aligned address");
	a_byte_store_lane: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_15
		mem_valid_o && mem_write_o && (scale_reg == cilsu_pkg::SCALE_BYTE) |-> $onehot(mem_byte_en_o))
		else $error("byte store enables wrong lanes");
	a_half_store_lanes: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_16
		mem_valid_o && mem_write_o && (scale_reg == cilsu_pkg::SCALE_HALF) |-> ($countones(mem_byte_en_o) == 2))
		else $error("halfword store enables wrong lanes");
	a_dword_store_full: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_18
		accept && !reserved && !ag.misaligned && (req_op_i == cilsu_pkg::store_doubleword)
		|=> (mem_byte_en_o == 8'hff) && (mem_wdata_o == $past(src_data)))
		else $error("doubleword store not full width");
	a_load_writeback: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_02
		(state_reg == cilsu_pkg::st_wait_load) && mem_rvalid_i |=> wb_valid_o ##1 !wb_valid_o)
		else $error("load data not written back");
	a_byte_sign_ext: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_02
		wb_valid_o && (scale_reg == cilsu_pkg::SCALE_BYTE) |->
		(wb_data_o[63:8] == (signed_reg ? {56{wb_data_o[7]}} : {56{1'b0}})))
		else $error("byte load extension wrong");
	a_byte_addr_sum: assert property (@(posedge clk_i) disable iff (reset_i) // RULE_01
		accept && !reserved && !req_extended_i && (scale == cilsu_pkg::SCALE_BYTE)
		&& (req_base_i == cilsu_pkg::base_general)
		|=> mem_valid_o && (mem_addr_o == $past(base_register_i) + $past(imm5_zx)))
		else $error("byte address sum wrong");

endmodule

`default_nettype wire

// *** core/cilsu_pkg.sv ***
// Constants and types for the compact load/store unit
// Function
// RULE_01: Byte accesses add zero-extended 5-bit offset to base register.
// RULE_02: Signed byte load sign-extends data; unsigned byte load zero-extends.
// RULE_03: Halfword offset shifted left one; signed/unsigned halfword extension.
// RULE_04: Halfword access with address bit 0 set raises address error.
// RULE_05: Register-based word load scales offset by four; sign-extends in 64-bit mode.
// RULE_06: Word access with either low address bit set raises address error.
// RULE_07: PC word load clears two low PC bits, adds 8-bit offset times four.
// RULE_08: Stack word access adds 8-bit offset times four to stack pointer.
// RULE_09: Unsigned word load zero-extends data; offset scaled by four.
// RULE_10: Unsigned word and doubleword ops in 32-bit user/supervisor raise reserved.
// RULE_11: Register or stack doubleword access scales 5-bit offset by eight.
// RULE_12: Doubleword access with any of three low bits set raises address error.
// RULE_13: PC doubleword load clears three low PC bits, adds 5-bit offset times eight.
// RULE_14: Return-address doubleword store uses 8-bit offset times eight, writes 64 bits.
// RULE_15: Byte store writes only the low byte of the data register.
// RULE_16: Halfword store writes only the low halfword of the data register.
// RULE_17: Return-address word store writes that register; 8-bit offset times four.
// RULE_18: Doubleword store writes the full 64-bit data register.
// RULE_19: PC-relative base is the instruction's exception return PC.
// RULE_20: Extended form replaces short offset with signed 16-bit offset.
// RULE_21: Faulting access makes no memory access and no register write.
// RULE_22: Stack word load checks both low address bits for alignment.
`default_nettype none

package cilsu_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned XLEN = 64;
	localparam int unsigned IMM_SHORT_W = 8;
	localparam int unsigned IMM_NARROW_W = 5;
	localparam int unsigned IMM_EXT_W = 16;
	localparam int unsigned LANES = 8;

	// ==========================================================
	// Offset scaling shifts per access size
	localparam logic [1:0] SCALE_BYTE = 2'h0;
	localparam logic [1:0] SCALE_HALF = 2'h1;
	localparam logic [1:0] SCALE_WORD = 2'h2;
	localparam logic [1:0] SCALE_DWORD = 2'h3;

	// Low address bits that must be zero, also the PC clear mask
	localparam logic [2:0] ALIGN_BYTE = 3'h0;
	localparam logic [2:0] ALIGN_HALF = 3'h1;
	localparam logic [2:0] ALIGN_WORD = 3'h3;
	localparam logic [2:0] ALIGN_DWORD = 3'h7;

	// Byte lane masks before shifting to the addressed lane
	localparam logic [7:0] LANES_BYTE = 8'h01;
	localparam logic [7:0] LANES_HALF = 8'h03;
	localparam logic [7:0] LANES_WORD = 8'h0f;
	localparam logic [7:0] LANES_DWORD = 8'hff;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		load_byte_signed,
		load_byte_unsigned,
		load_halfword_signed,
		load_halfword_unsigned,
		load_word,
		load_word_unsigned,
		load_doubleword,
		store_byte,
		store_halfword,
		store_word,
		store_doubleword
	} cilsu_op_t;

	typedef enum logic [1:0] {
		base_general,
		base_stack,
		base_pc
	} cilsu_base_t;

	typedef enum logic {
		st_idle,
		st_wait_load
	} cilsu_state_t;

endpackage

`default_nettype wire

// *** core/cilsu_agen_if.sv ***
// Signals between the load/store control and its address generator
`default_nettype none

interface cilsu_agen_if;
	logic [cilsu_pkg::XLEN-1:0] base;
	logic [cilsu_pkg::IMM_SHORT_W-1:0] short_imm;
	logic wide;
	logic extended;
	logic [cilsu_pkg::IMM_EXT_W-1:0] ext_imm;
	logic [1:0] scale;
	logic [2:0] align;
	logic pc_rel;
	logic [cilsu_pkg::XLEN-1:0] addr;
	logic misaligned;

	modport ctrl (output base, short_imm, wide, extended, ext_imm, scale, align, pc_rel, input addr, misaligned);
	modport agen (input base, short_imm, wide, extended, ext_imm, scale, align, pc_rel, output addr, misaligned);
endinterface

`default_nettype wire

// *** core/cilsu_agen.sv ***
// Virtual address generation and alignment check
`default_nettype none

module cilsu_agen (
	cilsu_agen_if.agen port
);

	logic [cilsu_pkg::XLEN-1:0] offs;
	logic [cilsu_pkg::XLEN-1:0] base_m;
	logic [cilsu_pkg::XLEN-1:0] short_zx;

	// Offset forming, base masking and sum
	always_comb begin
		if (port.wide) begin
			short_zx = {{(cilsu_pkg::XLEN-cilsu_pkg::IMM_SHORT_W){1'b0}}, port.short_imm}; // RULE_07 RULE_08 RULE_14 RULE_17
		end else begin
			short_zx = {{(cilsu_pkg::XLEN-cilsu_pkg::IMM_NARROW_W){1'b0}}, port.short_imm[cilsu_pkg::IMM_NARROW_W-1:0]}; // RULE_01
		end
		if (port.extended) begin
			offs = {{(cilsu_pkg::XLEN-cilsu_pkg::IMM_EXT_W){port.ext_imm[cilsu_pkg::IMM_EXT_W-1]}}, port.ext_imm}; // RULE_20
		end else begin
			offs = short_zx << port.scale; // RULE_03 RULE_05 RULE_09 RULE_11
		end
		if (port.pc_rel) begin
			base_m = port.base & ~{{(cilsu_pkg::XLEN-3){1'b0}}, port.align}; // RULE_07 RULE_13
		end else begin
			base_m = port.base;
		end
		port.addr = base_m + offs;
		port.misaligned = |(port.addr[2:0] & port.align); // RULE_04 RULE_06 RULE_12 RULE_22
	end

endmodule

`default_nettype wire

// *** tb/cilsu_mem_model.sv ***
// Data memory stand-in that answers loads after a chosen delay
`default_nettype none

module cilsu_mem_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic mem_valid_i,
	input wire logic mem_write_i,
	input wire logic [63:0] load_word_i,
	input wire logic [2:0] delay_i,
	output logic mem_rvalid_o,
	output logic [63:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic busy_reg;
	logic [2:0] count_reg;
	logic [63:0] word_reg;

	// Capture a load request and count down its latency
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_reg <= 1'b0;
			count_reg <= 3'h0;
			word_reg <= 64'h0;
		end else if (mem_valid_i && !mem_write_i) begin
			busy_reg <= 1'b1;
			count_reg <= delay_i;
			word_reg <= load_word_i;
		end else if (busy_reg) begin
			if (count_reg == 3'h0) begin
				busy_reg <= 1'b0;
			end else begin
				count_reg <= count_reg - 3'h1;
			end
		end
	end

	// Data is only meaningful with the valid pulse; otherwise the inverse
	assign mem_rvalid_o = busy_reg && (count_reg == 3'h0);
	assign mem_rdata_o = mem_rvalid_o ? word_reg : ~word_reg;
endmodule

`default_nettype wire

// *** tb/cilsu_lsu_tb.sv ***
// Self-checking bench for the compact load/store unit
`default_nettype none

module cilsu_lsu_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [2:0] kind;
		logic [63:0] addr;
		logic [7:0] be;
		logic [63:0] data;
	} cilsu_exp_t;

	logic clk_i, reset_i, req_valid_i, req_src_ra_i, req_extended_i, mode64_i, kernel_i;
	cilsu_pkg::cilsu_op_t req_op_i;
	cilsu_pkg::cilsu_base_t req_base_i;
	logic [7:0] req_imm_i;
	logic [15:0] req_ext_imm_i;
	logic [63:0] breg, sp, exception_return_pc, dreg, ra_val, load_word, mem_rdata_i;
	logic [2:0] rd_delay;
	logic req_ready_o, mem_valid_o, mem_write_o, mem_rvalid_i, wb_valid_o, addr_error_o, reserved_instr_o;
	logic [63:0] mem_addr_o, mem_wdata_o, wb_data_o, bad_vaddr_o;
	logic [7:0] mem_byte_en_o;
	cilsu_exp_t exp_q[$];
	int mismatches, checked;

	cilsu_lsu dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
		.req_base_i(req_base_i), .req_src_ra_i(req_src_ra_i), .req_imm_i(req_imm_i),
		.req_extended_i(req_extended_i), .req_ext_imm_i(req_ext_imm_i), .mode64_i(mode64_i),
		.kernel_i(kernel_i), .base_register_i(breg), .stack_pointer_register_i(sp),
		.exception_return_pc_i(exception_return_pc), .data_register_field_i(dreg), .return_address_register_i(ra_val),
		.req_ready_o(req_ready_o), .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o),
		.mem_addr_o(mem_addr_o), .mem_byte_en_o(mem_byte_en_o), .mem_wdata_o(mem_wdata_o),
		.mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .wb_valid_o(wb_valid_o),
		.wb_data_o(wb_data_o), .addr_error_o(addr_error_o), .reserved_instr_o(reserved_instr_o),
		.bad_vaddr_o(bad_vaddr_o));

	cilsu_mem_model mem (.clk_i(clk_i), .reset_i(reset_i), .mem_valid_i(mem_valid_o),
		.mem_write_i(mem_write_o), .load_word_i(load_word), .delay_i(rd_delay),
		.mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

	// Free-running core clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Compare one value and count it
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Print the counts and the verdict, then stop
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Random operand, mostly doubleword aligned
	function automatic logic [63:0] r64();
		r64 = {$urandom, $urandom};
		if ($urandom_range(3, 0) != 0) begin
			r64[2:0] = 3'h0;
		end
	endfunction

	// Issue one request at the current edge, note its results, wait until taken
	task automatic send(input cilsu_pkg::cilsu_op_t op, input cilsu_pkg::cilsu_base_t bs, input logic use_ra,
			input logic ext, input logic m64, input logic kern);
		logic [63:0] b, g, s, e, r, w, base, off, addr, raw, res;
		logic [15:0] eimm;
		logic [7:0] imm, be;
		logic [2:0] am;
		logic [1:0] sc;
		logic is_load, rsv, wide;
		int n;
		b = r64();
		g = r64();
		s = r64();
		e = r64();
		r = r64();
		w = {$urandom, $urandom};
		imm = 8'($urandom);
		eimm = 16'(r64());
		is_load = op <= cilsu_pkg::load_doubleword;
		case (op)
			cilsu_pkg::load_byte_signed, cilsu_pkg::load_byte_unsigned, cilsu_pkg::store_byte: sc = 2'h0;
			cilsu_pkg::load_halfword_signed, cilsu_pkg::load_halfword_unsigned, cilsu_pkg::store_halfword: sc = 2'h1;
			cilsu_pkg::load_doubleword, cilsu_pkg::store_doubleword: sc = 2'h3;
			default: sc = 2'h2;
		endcase
		am = 3'((4'h1 << sc) - 4'h1);
		wide = (sc == 2'h2 && bs != cilsu_pkg::base_general) || (op == cilsu_pkg::store_doubleword && use_ra);
		off = ext ? {{48{eimm[15]}}, eimm} : (64'(wide ? imm : {3'h0, imm[4:0]}) << sc);
		base = (bs == cilsu_pkg::base_stack) ? s : (bs == cilsu_pkg::base_general) ? b : (e & ~64'(sc[1] ? am : 3'h0));
		addr = base + off;
		rsv = (op inside {cilsu_pkg::load_word_unsigned, cilsu_pkg::load_doubleword, cilsu_pkg::store_doubleword})
			&& !m64 && !kern;
		be = 8'(8'((16'h1 << (4'h1 << sc)) - 16'h1) << addr[2:0]);
		raw = w >> (8 * addr[2:0]);
		case (op)
			cilsu_pkg::load_byte_signed: res = {{56{raw[7]}}, raw[7:0]};
			cilsu_pkg::load_byte_unsigned: res = {56'h0, raw[7:0]};
			cilsu_pkg::load_halfword_signed: res = {{48{raw[15]}}, raw[15:0]};
			cilsu_pkg::load_halfword_unsigned: res = {48'h0, raw[15:0]};
			cilsu_pkg::load_word: res = {{32{raw[31] & m64}}, raw[31:0]};
			cilsu_pkg::load_word_unsigned: res = {32'h0, raw[31:0]};
			default: res = raw;
		endcase
		req_valid_i <= 1'b1;
		req_op_i <= op;
		req_base_i <= bs;
		req_src_ra_i <= use_ra;
		req_imm_i <= imm;
		req_extended_i <= ext;
		req_ext_imm_i <= eimm;
		mode64_i <= m64;
		kernel_i <= kern;
		breg <= b;
		sp <= s;
		exception_return_pc <= e;
		dreg <= g;
		ra_val <= r;
		load_word <= w;
		rd_delay <= 3'($urandom_range(7, 0));
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			tally_and_finish();
		end
		if (rsv) begin
			exp_q.push_back('{3'h4, 64'h0, 8'h0, 64'h0});
		end else if ((addr[2:0] & am) != 3'h0) begin
			exp_q.push_back('{3'h3, addr, 8'h0, 64'h0});
		end else if (!is_load) begin
			exp_q.push_back('{3'h0, addr, be, (use_ra ? r : g) << (8 * addr[2:0])});
		end else begin
			exp_q.push_back('{3'h1, addr, be, 64'h0});
			exp_q.push_back('{3'h2, 64'h0, 8'h0, res});
			// A load holds the request path: drop the request until ready returns
			req_valid_i <= 1'b0;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (req_ready_o !== 1'b1 && n < 50);
			if (n >= 50) begin
				mismatches++;
				tally_and_finish();
			end
		end
	endtask

	// Take the oldest note for one observed result and compare
	task automatic take(input logic [2:0] kind);
		cilsu_exp_t x;
		logic [63:0] m;
		x = '{3'h7, 64'h0, 8'h0, 64'h0};
		if (exp_q.size() != 0) begin
			x = exp_q.pop_front();
		end
		m = 64'h0;
		for (int i = 0; i < 8; i++) begin
			m[8*i+:8] = {8{x.be[i]}};
		end
		chk("result kind", 64'(x.kind), 64'(kind));
		if (kind <= 3'h1) begin
			chk("memory address", x.addr, mem_addr_o);
			chk("byte enables", 64'(x.be), 64'(mem_byte_en_o));
		end
		if (kind == 3'h0) begin
			chk("store data", x.data & m, mem_wdata_o & m);
		end
		if (kind == 3'h2) begin
			chk("load result", x.data, wb_data_o);
		end
		if (kind == 3'h3) begin
			chk("faulting address", x.addr, bad_vaddr_o);
		end
	endtask

	// Output watcher, sampling where outputs are settled
	always @(negedge clk_i) begin
		if (reset_i === 1'b0) begin
			if (wb_valid_o === 1'b1) take(3'h2);
			if (mem_valid_o === 1'b1) take(mem_write_o === 1'b1 ? 3'h0 : 3'h1);
			if (addr_error_o === 1'b1) take(3'h3);
			if (reserved_instr_o === 1'b1) take(3'h4);
		end
	end

	// Main sequence: every operation in every mode, then random traffic
	initial begin
		cilsu_pkg::cilsu_op_t op;
		cilsu_pkg::cilsu_base_t bs;
		logic [1:0] md;
		void'($urandom(32'haeac_c408));
		{reset_i, req_valid_i, req_src_ra_i, req_extended_i, mode64_i, kernel_i} = 6'h20;
		req_op_i = cilsu_pkg::load_byte_signed;
		req_base_i = cilsu_pkg::base_general;
		{req_imm_i, req_ext_imm_i, breg, sp, exception_return_pc, dreg, ra_val, load_word, rd_delay} = '0;
		repeat (16) @(posedge clk_i);
		chk("ready in reset", 64'h1, 64'(req_ready_o));
		chk("address in reset", 64'h0, mem_addr_o);
		reset_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 700; i++) begin
			op = cilsu_pkg::cilsu_op_t'(i < 44 ? i % 11 : $urandom_range(10, 0));
			md = 2'(i < 44 ? i / 11 : $urandom_range(3, 0));
			bs = cilsu_pkg::cilsu_base_t'($urandom_range(2, 0));
			if (!(op inside {cilsu_pkg::load_word, cilsu_pkg::store_word, cilsu_pkg::load_doubleword,
					cilsu_pkg::store_doubleword})) bs = cilsu_pkg::base_general;
			if (op > cilsu_pkg::load_doubleword && bs == cilsu_pkg::base_pc) bs = cilsu_pkg::base_stack;
			send(op, bs, bs == cilsu_pkg::base_stack && op > cilsu_pkg::load_doubleword && $urandom_range(1, 0) == 1,
				$urandom_range(3, 0) == 0, md[0], md[1]);
		end
		req_valid_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		chk("notes left over", 64'h0, 64'(exp_q.size()));
		tally_and_finish();
	end
endmodule

`default_nettype wire
